// File: core/tpc_capture.sv
/*
 Capture engine: arms on command, waits for a trigger, stores the
 serial pattern into block memory, then serves block readout.
 Assumes rxBit/rxErr/auxTrigIn arrive with clk_link; all control
 ports are synchronous to clk_sys. Settings stay still while active.
*/
`timescale 1ns/10ps
// What this block does
// RULE1: Command arms, waits trigger, fills, stops
// RULE2: Block count 1 to 128, powers of two
// RULE3: Block size is 8 Mbit over count
// RULE4: Error mode triggers on detected bit error
// RULE5: Match mode triggers on equal received bits
// RULE6: Match length 4 to 64, match mode only
// RULE7: Manual mode: one block per trigger command
// RULE8: Manual command ignored unless source manual
// RULE9: External: synchronised aux falling edge triggers
// RULE10: Capture refused under inhibiting measurement settings
// RULE11: Host loads conditions before capture command
// RULE12: Mask one excludes bit from matching
// RULE13: Placement after, around or before trigger
// RULE14: Record trigger bit offset per block
// RULE15: Host reads blocks and captured block count
module tpc_capture import tpc_pkg::*; (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic clk_link,
  input wire logic rxBit,
  input wire logic rxErr,
  input wire logic auxTrigIn,
  input wire logic startCmd,
  input wire logic trigCmd,
  input wire tpc_trig_type trigSrc,
  input wire logic [BLK_SEL_W-1:0] blkSel,
  input wire logic [LEN_CODE_W-1:0] matchLen,
  input wire logic [MATCH_W-1:0] matchWord,
  input wire logic [MATCH_W-1:0] matchMask,
  input wire tpc_place_type place,
  input wire logic burstSel,
  input wire logic four_lane_merge,
  input wire logic quickSync,
  input wire logic syncLost,
  input wire logic multiInput,
  input wire logic rdStart,
  input wire logic [BLK_IDX_W-1:0] rdBlock,
  input wire logic outReady,
  output logic captureActive,
  output logic startRefused,
  output logic [BLK_CNT_W-1:0] blocksCaptured,
  output logic rdBusy,
  output logic [BITCNT_W-1:0] trigOffset,
  output logic outValid,
  output logic [WORD_W-1:0] outData
);
  // Storage shared by both domains: link writes, system reads when idle
  logic [WORD_W-1:0] capMem [0:MEM_WORDS-1];
  logic [ADDR_W-1:0] startPtr [0:BLK_MAX-1]; // Oldest word per block
  logic [BITCNT_W-1:0] offs [0:BLK_MAX-1]; // Trigger offset per block

  // System domain state
  logic captureActive_q;
  logic startRefused_q;
  logic rdBusy_q;
  logic startTgl_q; // Toggles per accepted start
  logic manTgl_q; // Toggles per accepted manual trigger
  tpc_trig_type cfgSrc_q;
  tpc_place_type cfgPlace_q;
  logic [BLK_SEL_W-1:0] cfgBlk_q;
  logic [LEN_CODE_W-1:0] cfgLen_q;
  logic [MATCH_W-1:0] cfgWord_q;
  logic [MATCH_W-1:0] cfgMask_q;
  logic [BLK_CNT_W-1:0] blocksCaptured_q;
  logic [BITCNT_W-1:0] trigOffset_q;
  logic doneS1_q, doneS2_q, doneS3_q; // Done toggle synchroniser
  logic [ADDR_W-1:0] rdBase_q, rdOff_q;
  logic [ADDR_W:0] rdLeft_q;
  logic memVal_q;
  logic [WORD_W-1:0] memData_q;

  // Link domain state
  logic lRst1_q, lnkRstn_q; // Reset release synchroniser
  logic startS1_q, startS2_q, startS3_q;
  logic manS1_q, manS2_q, manS3_q;
  logic auxS1_q, auxS2_q, auxS3_q;
  tpc_link_type lState_q;
  logic doneTgl_q;
  logic [MATCH_W-1:0] matchSr_q; // Newest bit in bit 0
  logic [WORD_W-1:0] wordSr_q;
  logic [4:0] bitCnt_q;
  logic [ADDR_W-1:0] wOff_q;
  logic [BLK_IDX_W-1:0] curBlk_q;
  logic [BITCNT_W-1:0] afterCnt_q;
  logic [BLK_CNT_W-1:0] lnkBlkCnt_q;

  // Combinational helpers
  logic inhibit, startOk, doneEv, issue, rdOk;
  logic startEv, manEv, auxFall, matchHit, trigHit, wordDone, finish;
  logic lastBlk;
  logic [LEN_W-1:0] lenBits;
  logic [MATCH_W-1:0] lenMask;
  logic [ADDR_W:0] blkWords, sysWords;
  logic [BITCNT_W-1:0] blkBits, postBits, afterNext;
  logic [ADDR_W-1:0] lBase, wOffNext;
  logic [BLK_CNT_W-1:0] nBlocks;

  tpc_stream_if bufIn();
  tpc_stream_if bufOut();

  // Readout buffer; host stall backs up into the memory reader
  tpc_skid_buf uBuf (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .inSide(bufIn.snk),
    .outSide(bufOut.src)
  );

  assign bufIn.valid = memVal_q;
  assign bufIn.data = memData_q;
  assign bufOut.ready = outReady;
  assign outValid = bufOut.valid;
  assign outData = bufOut.data;
  assign captureActive = captureActive_q;
  assign startRefused = startRefused_q;
  assign blocksCaptured = blocksCaptured_q;
  assign rdBusy = rdBusy_q;
  assign trigOffset = trigOffset_q;

  // Measurement settings that forbid capture
  assign inhibit = burstSel || four_lane_merge || quickSync || syncLost || multiInput; // [RULE10]
  assign startOk = startCmd && !captureActive_q && !rdBusy_q && !inhibit; // [RULE10]
  assign doneEv = doneS2_q ^ doneS3_q;

  // Start, refusal and configuration snapshot
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      captureActive_q <= 1'b0;
      startRefused_q <= 1'b0;
      startTgl_q <= 1'b0;
      cfgSrc_q <= TRIG_ERROR;
      cfgPlace_q <= PLACE_TOP;
      cfgBlk_q <= '0;
      cfgLen_q <= '0;
      cfgWord_q <= '0;
      cfgMask_q <= '0;
    end else begin
      startRefused_q <= startCmd && !startOk;
      if (startOk) begin
        // Snapshot: later edits do not reach the running capture, save trigSrc in the manual gate
        captureActive_q <= 1'b1; // [RULE1]
        startTgl_q <= !startTgl_q;
        cfgSrc_q <= trigSrc; // [RULE11]
        cfgPlace_q <= place;
        cfgBlk_q <= blkSel; // [RULE2]
        cfgLen_q <= matchLen;
        cfgWord_q <= matchWord;
        cfgMask_q <= matchMask;
      end else if (doneEv) begin
        captureActive_q <= 1'b0; // [RULE1]
      end
    end
  end

  // Manual trigger and done crossing
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      manTgl_q <= 1'b0;
      doneS1_q <= 1'b0;
      doneS2_q <= 1'b0;
      doneS3_q <= 1'b0;
      blocksCaptured_q <= '0;
    end else begin
      doneS1_q <= doneTgl_q;
      doneS2_q <= doneS1_q;
      doneS3_q <= doneS2_q;
      // Only a manual source both armed and selected now
      if (trigCmd && captureActive_q && trigSrc == TRIG_MANUAL && cfgSrc_q == TRIG_MANUAL) begin
        manTgl_q <= !manTgl_q; // [RULE8]
      end
      // Link count is still once done toggles
      if (doneEv) begin
        blocksCaptured_q <= lnkBlkCnt_q; // [RULE15]
      end
    end
  end

  // Readout geometry from the snapshot
  assign sysWords = (ADDR_W+1)'(MEM_WORDS) >> cfgBlk_q; // [RULE3]
  assign rdOk = rdStart && !captureActive_q && !rdBusy_q && ({1'b0, rdBlock} < blocksCaptured_q);
  // One read in flight at most, so the buffer always has room
  assign issue = rdBusy_q && bufIn.ready && !memVal_q;

  // Block readout engine
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rdBusy_q <= 1'b0;
      rdBase_q <= '0;
      rdOff_q <= '0;
      rdLeft_q <= '0;
      memVal_q <= 1'b0;
      memData_q <= WORD_RST;
      trigOffset_q <= '0;
    end else begin
      memVal_q <= issue;
      if (rdOk) begin
        rdBusy_q <= 1'b1; // [RULE15]
        rdBase_q <= ADDR_W'(ADDR_W'(rdBlock) * sysWords);
        rdOff_q <= startPtr[rdBlock];
        rdLeft_q <= sysWords;
        trigOffset_q <= offs[rdBlock]; // [RULE14]
      end else if (issue) begin
        memData_q <= capMem[rdBase_q + rdOff_q];
        rdOff_q <= ({1'b0, rdOff_q} == sysWords - 1'b1) ? '0 : rdOff_q + 1'b1;
        rdLeft_q <= rdLeft_q - 1'b1;
        rdBusy_q <= rdLeft_q != 1;
      end
    end
  end

  // Link reset release held back two link edges
  always_ff @(posedge clk_link or negedge rstn) begin
    if (!rstn) begin
      lRst1_q <= 1'b0;
      lnkRstn_q <= 1'b0;
    end else begin
      lRst1_q <= 1'b1;
      lnkRstn_q <= lRst1_q;
    end
  end

  // Event synchronisers into the link domain
  always_ff @(posedge clk_link or negedge lnkRstn_q) begin
    if (!lnkRstn_q) begin
      {startS1_q, startS2_q, startS3_q} <= 3'h0;
      {manS1_q, manS2_q, manS3_q} <= 3'h0;
      {auxS1_q, auxS2_q, auxS3_q} <= 3'h7;
    end else begin
      {startS1_q, startS2_q, startS3_q} <= {startTgl_q, startS1_q, startS2_q};
      {manS1_q, manS2_q, manS3_q} <= {manTgl_q, manS1_q, manS2_q};
      {auxS1_q, auxS2_q, auxS3_q} <= {auxTrigIn, auxS1_q, auxS2_q}; // [RULE9]
    end
  end

  assign startEv = startS2_q ^ startS3_q;
  assign manEv = manS2_q ^ manS3_q;
  assign auxFall = auxS3_q && !auxS2_q; // [RULE9]

  // Match compare, low bits of the word meet the newest bits
  assign lenBits = LEN_W'((cfgLen_q + 1'b1) * MATCH_STEP); // [RULE6]
  assign lenMask = ~(ALL_ONES << lenBits); // [RULE6]
  assign matchHit = ((matchSr_q ^ cfgWord_q) & ~cfgMask_q & lenMask) == '0; // [RULE12]

  // Trigger selection; match settings act only in match mode
  always_comb begin
    case (cfgSrc_q)
      TRIG_ERROR: trigHit = rxErr; // [RULE4]
      TRIG_MATCH: trigHit = matchHit; // [RULE5]
      TRIG_MANUAL: trigHit = manEv; // [RULE7]
      TRIG_EXTERNAL: trigHit = auxFall; // [RULE9]
      default: trigHit = 1'b0;
    endcase
  end

  // Block geometry and post-trigger length
  assign blkWords = (ADDR_W+1)'(MEM_WORDS) >> cfgBlk_q; // [RULE3]
  assign blkBits = BITCNT_W'(MEM_BITS) >> cfgBlk_q; // [RULE3]
  assign nBlocks = BLK_CNT_W'(1) << cfgBlk_q; // [RULE2]
  assign lBase = ADDR_W'(curBlk_q) << (ADDR_W - int'(cfgBlk_q));
  always_comb begin
    case (cfgPlace_q)
      PLACE_TOP: postBits = blkBits; // [RULE13]
      PLACE_MIDDLE: postBits = blkBits >> 1; // [RULE13]
      PLACE_BOTTOM: postBits = '0; // [RULE13]
      default: postBits = blkBits;
    endcase
  end

  assign wordDone = bitCnt_q == 5'h1F;
  assign wOffNext = ({1'b0, wOff_q} == blkWords - 1'b1) ? '0 : wOff_q + 1'b1;
  assign afterNext = afterCnt_q + 1'b1;
  assign finish = lState_q == LK_POST && wordDone && afterNext >= postBits;
  assign lastBlk = {1'b0, curBlk_q} + 1'b1 == nBlocks;

  // Pattern history for matching
  always_ff @(posedge clk_link or negedge lnkRstn_q) begin
    if (!lnkRstn_q) begin
      matchSr_q <= '0;
    end else begin
      matchSr_q <= {matchSr_q[MATCH_W-2:0], rxBit};
    end
  end

  // Word assembly and circular store; runs armed too for pre-trigger data
  always_ff @(posedge clk_link or negedge lnkRstn_q) begin
    if (!lnkRstn_q) begin
      wordSr_q <= WORD_RST;
      bitCnt_q <= '0;
      wOff_q <= '0;
    end else if (lState_q == LK_IDLE) begin
      bitCnt_q <= '0;
      wOff_q <= '0;
    end else begin
      wordSr_q <= {wordSr_q[WORD_W-2:0], rxBit};
      bitCnt_q <= bitCnt_q + 1'b1;
      if (wordDone) begin
        wOff_q <= finish ? '0 : wOffNext;
      end
    end
  end

  // Memory write port on the link clock
  always_ff @(posedge clk_link) begin
    if (lState_q != LK_IDLE && wordDone) begin
      capMem[lBase + wOff_q] <= {wordSr_q[WORD_W-2:0], rxBit};
    end
  end

  // Per-block results, written as each block closes
  always_ff @(posedge clk_link) begin
    if (finish) begin
      startPtr[curBlk_q] <= wOffNext;
      offs[curBlk_q] <= blkBits - afterNext; // [RULE14]
    end
  end

  // Link capture sequencer
  always_ff @(posedge clk_link or negedge lnkRstn_q) begin
    if (!lnkRstn_q) begin
      lState_q <= LK_IDLE;
      doneTgl_q <= 1'b0;
      curBlk_q <= '0;
      afterCnt_q <= '0;
      lnkBlkCnt_q <= '0;
    end else begin
      case (lState_q)
        LK_IDLE: begin
          if (startEv) begin
            lState_q <= LK_ARM; // [RULE1]
            curBlk_q <= '0;
          end
        end
        LK_ARM: begin
          // Standby until the selected trigger appears
          if (trigHit) begin
            lState_q <= LK_POST;
            afterCnt_q <= BITCNT_W'(1);
          end
        end
        LK_POST: begin
          afterCnt_q <= afterNext;
          if (finish && lastBlk) begin
            lState_q <= LK_IDLE; // [RULE1]
            doneTgl_q <= !doneTgl_q;
            lnkBlkCnt_q <= nBlocks;
          end else if (finish) begin
            // Next block waits for its own trigger
            lState_q <= LK_ARM; // [RULE7]
            curBlk_q <= curBlk_q + 1'b1;
          end
        end
        default: lState_q <= LK_IDLE;
      endcase
    end
  end

  a_start_refused: assert property (@(posedge clk_sys) disable iff (!rstn) // [RULE10]
    startCmd && inhibit && !captureActive_q |=> startRefused_q && !captureActive_q)
    else $error("capture started under inhibit");
  a_start_active: assert property (@(posedge clk_sys) disable iff (!rstn) // [RULE1]
    startOk |=> captureActive_q && startTgl_q != $past(startTgl_q))
    else $error("accepted start not shown as active");
  a_manual_gate: assert property (@(posedge clk_sys) disable iff (!rstn) // [RULE8]
    trigCmd && trigSrc != TRIG_MANUAL |=> $stable(manTgl_q))
    else $error("manual trigger taken in wrong source");
  a_error_trig: assert property (@(posedge clk_link) disable iff (!lnkRstn_q) // [RULE4]
    lState_q == LK_ARM && cfgSrc_q == TRIG_ERROR && rxErr |=> lState_q == LK_POST)
    else $error("bit error did not trigger");
  a_match_trig: assert property (@(posedge clk_link) disable iff (!lnkRstn_q) // [RULE5]
    lState_q == LK_ARM && cfgSrc_q == TRIG_MATCH && matchHit |=> lState_q == LK_POST)
    else $error("match did not trigger");
  a_ext_edge: assert property (@(posedge clk_link) disable iff (!lnkRstn_q) // [RULE9]
    lState_q == LK_ARM && cfgSrc_q == TRIG_EXTERNAL && !auxS2_q && auxS3_q |=> lState_q == LK_POST)
    else $error("aux falling edge did not trigger");
  a_arm_holds: assert property (@(posedge clk_link) disable iff (!lnkRstn_q) // [RULE1]
    lState_q == LK_ARM && !trigHit |=> lState_q == LK_ARM)
    else $error("left standby without trigger");
  a_block_count: assert property (@(posedge clk_link) disable iff (!lnkRstn_q) // [RULE2]
    finish && lastBlk |=> lnkBlkCnt_q == (BLK_CNT_W'(1) << cfgBlk_q) && lState_q == LK_IDLE)
    else $error("wrong captured block count");
  a_post_len: assert property (@(posedge clk_link) disable iff (!lnkRstn_q) // [RULE13]
    // A trigger on a word's last bit leaves that bit plus one full word: 33 bits
    finish |-> afterNext >= postBits && afterNext < postBits + 34)
    else $error("post-trigger length off");
  a_push_room: assert property (@(posedge clk_sys) disable iff (!rstn) // [RULE15]
    issue |=> bufIn.ready && memVal_q)
    else $error("readout word pushed into full buffer");

  c_start: cover property (@(posedge clk_sys) disable iff (!rstn) startOk);
  c_trigger: cover property (@(posedge clk_link) disable iff (!lnkRstn_q)
    lState_q == LK_ARM && trigHit);
  c_done: cover property (@(posedge clk_sys) disable iff (!rstn) doneEv);
  c_stall: cover property (@(posedge clk_sys) disable iff (!rstn) outValid && !outReady ##1 outValid && outReady);
endmodule : tpc_capture

// File: common/tpc_pkg.sv
/*
 Constants and types of the test pattern capture engine.
 Assumes a one-bit-per-link-clock serial pattern stream.
*/
package tpc_pkg;
  // Capture memory geometry
  localparam int MEM_BITS = 8388608;
  localparam int WORD_W = 32;
  localparam int MEM_WORDS = MEM_BITS / WORD_W;
  localparam int ADDR_W = 18;
  localparam int BITCNT_W = 24;
  // Block count is 2**blkSel, 1 to 128
  localparam int BLK_SEL_W = 3;
  localparam int BLK_IDX_W = 7;
  localparam int BLK_CNT_W = 8;
  localparam int BLK_MAX = 128;
  // Match word: length (code+1)*4 bits
  localparam int MATCH_W = 64;
  localparam int MATCH_STEP = 4;
  localparam int LEN_CODE_W = 4;
  localparam int LEN_W = 7;
  localparam logic [MATCH_W-1:0] ALL_ONES = '1;
  // Reset values
  localparam logic [WORD_W-1:0] WORD_RST = 32'h0000_0000;
  // Trigger sources
  typedef enum logic [1:0] {
    TRIG_ERROR, TRIG_MATCH, TRIG_MANUAL, TRIG_EXTERNAL
  } tpc_trig_type;
  // Capture placement against the trigger
  typedef enum logic [1:0] {
    PLACE_TOP, PLACE_MIDDLE, PLACE_BOTTOM
  } tpc_place_type;
  // Link-side capture states
  typedef enum logic [1:0] {
    LK_IDLE, LK_ARM, LK_POST
  } tpc_link_type;
endpackage : tpc_pkg

// File: common/tpc_stream_if.sv
/*
 Word stream with valid and ready between capture core and buffer.
 Assumes both ends run on the system clock.
*/
`timescale 1ns/10ps
interface tpc_stream_if import tpc_pkg::*; ();
  logic valid; // Word offered
  logic ready; // Word may be taken
  logic [WORD_W-1:0] data; // Word payload
  modport src(output valid, output data, input ready);
  modport snk(input valid, input data, output ready);
endinterface : tpc_stream_if

// File: core/tpc_skid_buf.sv
/*
 Two-entry buffer on the readout path; all outputs are flops.
 Assumes source and sink share clk_sys.
*/
`timescale 1ns/10ps
module tpc_skid_buf import tpc_pkg::*; (
  input wire logic clk_sys,
  input wire logic rstn,
  tpc_stream_if.snk inSide,
  tpc_stream_if.src outSide
);
  logic headVal_q; // Head entry holds a word
  logic spareVal_q; // Spare entry holds a word
  logic [WORD_W-1:0] head_q;
  logic [WORD_W-1:0] spare_q;
  logic push;
  logic pop;

  // Ready only while the spare slot is free, so a stall never drops a word
  assign inSide.ready = !spareVal_q;
  assign outSide.valid = headVal_q;
  assign outSide.data = head_q;
  assign push = inSide.valid && !spareVal_q;
  assign pop = headVal_q && outSide.ready;

  // Head refills from spare first to keep order
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      headVal_q <= 1'b0;
      spareVal_q <= 1'b0;
      head_q <= WORD_RST;
      spare_q <= WORD_RST;
    end else if (!headVal_q || pop) begin
      if (spareVal_q) begin
        head_q <= spare_q;
        headVal_q <= 1'b1;
        spareVal_q <= 1'b0;
      end else begin
        headVal_q <= push;
        if (push) begin
          head_q <= inSide.data;
        end
      end
    end else if (push) begin
      // Head stalled: park word in spare
      spareVal_q <= 1'b1;
      spare_q <= inSide.data;
    end
  end

  a_buf_hold: assert property (@(posedge clk_sys) disable iff (!rstn)
    headVal_q && !outSide.ready |=> headVal_q && $stable(head_q))
    else $error("buffer head changed while stalled");
endmodule : tpc_skid_buf

// File: tb/tpc_pattern_src.sv
/*
 Serial pattern source standing for the device under test.
 Assumes clk_link runs free and the bench asks for events by levels.
*/
`timescale 1ns/10ps
module tpc_pattern_src (
  input wire logic clk_link,
  input wire logic errReq,
  input wire logic oneReq,
  output logic rxBit,
  output logic rxErr
);
  logic oneSeen_q; // Last oneReq, for edge finding
  // All-zero stream with a single 1 bit per rising oneReq, so a match word can be placed
  always_ff @(posedge clk_link) begin
    oneSeen_q <= oneReq;
    rxBit <= oneReq & ~oneSeen_q;
    rxErr <= errReq; // Error flags as long as asked
  end
endmodule : tpc_pattern_src

// File: tb/test_pattern_capture_trigger_bench.sv
/*
 Bench of the capture engine: a table of trigger cases, then hand tests.
 Assumes tpc_pkg and the pattern source model are compiled first.
*/
`timescale 1ns/10ps
module test_pattern_capture_trigger_bench import tpc_pkg::*; ();
  logic clk_sys = 1'b0; // 50 ns
  logic clk_link = 1'b0; // 12 ns, own phase
  logic rstn = 1'b0;
  logic errReq = 1'b0, oneReq = 1'b0, rxBit, rxErr;
  logic auxTrigIn = 1'b1; // Pin idles high
  logic startCmd = 1'b0, trigCmd = 1'b0, rdStart = 1'b0, outReady = 1'b1;
  tpc_trig_type trigSrc = TRIG_ERROR;
  logic [BLK_SEL_W-1:0] blkSel = 3'h0;
  logic [LEN_CODE_W-1:0] matchLen = 4'h0;
  logic [MATCH_W-1:0] matchWord = 64'h0, matchMask = 64'h0;
  tpc_place_type place = PLACE_BOTTOM; // Bottom ends a block soon after its trigger
  logic [4:0] inhibit = 5'h00; // Burst, merge, quick, lost, multi
  logic [BLK_IDX_W-1:0] rdBlock = 7'h00;
  logic captureActive, startRefused, rdBusy, outValid, refSeen;
  logic [BLK_CNT_W-1:0] blocksCaptured;
  logic [BITCNT_W-1:0] trigOffset;
  logic [WORD_W-1:0] outData, firstWord;
  int bad_count = 0, n_tests = 0, cycles = 0, k, w;
  int blkBits = MEM_BITS / BLK_MAX; // Block size at 128 blocks
  // Trigger case table
  typedef struct {
    tpc_trig_type src;
    logic [LEN_CODE_W-1:0] len;
    logic [MATCH_W-1:0] word;
    logic [MATCH_W-1:0] mask;
    logic [BLK_CNT_W-1:0] expBlocks;
  } tpc_row_type;
  tpc_row_type rows [6] = '{
    '{TRIG_ERROR, 4'h0, 64'h0, 64'h0, 8'h01}, // Error flag fires
    '{TRIG_MATCH, 4'hf, 64'h0, 64'h0, 8'h01}, // Full 64-bit word
    '{TRIG_MATCH, 4'h1, 64'h100, 64'h0, 8'h01}, // Bit past length unused
    '{TRIG_MATCH, 4'h1, 64'h3, 64'h3, 8'h01}, // Masked bits unused
    '{TRIG_MANUAL, 4'h0, 64'h0, 64'h0, 8'h01}, // Host trigger
    '{TRIG_EXTERNAL, 4'h0, 64'h0, 64'h0, 8'h01} // Aux fall
  };

  tpc_capture dut_u (.clk_sys, .rstn, .clk_link, .rxBit, .rxErr, .auxTrigIn, .startCmd, .trigCmd,
    .trigSrc, .blkSel, .matchLen, .matchWord, .matchMask, .place, .burstSel(inhibit[0]),
    .four_lane_merge(inhibit[1]), .quickSync(inhibit[2]), .syncLost(inhibit[3]),
    .multiInput(inhibit[4]), .rdStart, .rdBlock, .outReady, .captureActive, .startRefused,
    .blocksCaptured, .rdBusy, .trigOffset, .outValid, .outData);
  tpc_pattern_src srcModel (.clk_link, .errReq, .oneReq, .rxBit, .rxErr);

  // Clocks
  initial begin
    forever #25 clk_sys = ~clk_sys;
  end
  initial begin
    #3;
    forever #6 clk_link = ~clk_link;
  end
  // Hang guard, about four times the expected run
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      bad_count++;
      end_sim();
    end
  end

  // Step n edges, then drive a little later
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #2;
  endtask : tick
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // Start pulse; refusal may show one or two cycles on
  task automatic start(output logic refused);
    startCmd = 1'b1;
    tick(1);
    refused = startRefused;
    startCmd = 1'b0;
    tick(1);
    refused = refused | startRefused;
    tick(1);
  endtask : start
  // Bounded wait for capture end
  task automatic wait_done(input int lim);
    int n;
    n = 0;
    while (captureActive !== 1'b0 && n < lim) begin
      tick(1);
      n++;
    end
  endtask : wait_done
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_sim

  initial begin
    tick(16);
    rstn = 1'b1;
    tick(4);
    // Table: one block per trigger kind
    foreach (rows[i]) begin
      trigSrc = rows[i].src; // Settings loaded before start
      matchLen = rows[i].len;
      matchWord = rows[i].word;
      matchMask = rows[i].mask;
      auxTrigIn = (rows[i].src == TRIG_EXTERNAL) ? 1'b0 : 1'b1;
      tick(2);
      start(refSeen);
      check("refused", refSeen, 0); // Clean settings accepted
      check("active", captureActive, 1); // Start raises active
      if (rows[i].src != TRIG_MATCH) begin
        auxTrigIn = 1'b1; // Rising aux must not fire
        tick(20);
        check("armed", captureActive, 1); // Waits for its trigger
      end
      case (rows[i].src)
        TRIG_ERROR: errReq = 1'b1;
        TRIG_MANUAL: trigCmd = 1'b1;
        TRIG_EXTERNAL: auxTrigIn = 1'b0;
        default: ;
      endcase
      tick(1);
      errReq = 1'b0;
      trigCmd = 1'b0;
      wait_done(400);
      check("done", captureActive, 0); // Stops soon after its trigger
      check("blocks", blocksCaptured, rows[i].expBlocks); // Count of 2**0
      $display("row %0d done", i);
    end
    // Each inhibit refuses a start
    for (k = 0; k < 5; k++) begin
      inhibit = 5'h00;
      inhibit[k] = 1'b1;
      tick(1);
      start(refSeen);
      check("inhibit refused", refSeen, 1); // Setting blocks start
      check("inhibit idle", captureActive, 0); // Nothing armed
    end
    inhibit = 5'h00;
    $display("inhibit test done");
    // Twelve-bit word 0x100; host trigger must be ignored in match mode
    trigSrc = TRIG_MATCH;
    matchLen = 4'h2;
    matchWord = 64'h100;
    matchMask = 64'h0;
    tick(2);
    start(refSeen);
    trigCmd = 1'b1;
    tick(1);
    trigCmd = 1'b0;
    tick(100);
    check("match wait", captureActive, 1); // Zeros differ, host trigger dropped
    oneReq = 1'b1; // One 1 bit, eight zeros later the word matches
    tick(1);
    oneReq = 1'b0;
    wait_done(400);
    check("match fired", captureActive, 0); // Length honoured
    rdBlock = 7'h01; // Past the single captured block
    rdStart = 1'b1;
    tick(1);
    rdStart = 1'b0;
    tick(2);
    check("rd refused", rdBusy, 0); // Only captured blocks readable
    $display("match test done");
    // 128 blocks need 128 host triggers
    trigSrc = TRIG_MANUAL;
    blkSel = 3'h7;
    tick(2);
    start(refSeen);
    start(refSeen);
    check("busy refused", refSeen, 1); // Second start while active
    for (k = 1; k <= BLK_MAX; k++) begin
      if (k == BLK_MAX) check("one short", captureActive, 1); // Still waiting
      trigCmd = 1'b1;
      tick(1);
      trigCmd = 1'b0;
      tick(24);
    end
    wait_done(100);
    check("all done", captureActive, 0);
    check("blocks 128", blocksCaptured, BLK_MAX); // Largest count
    $display("manual test done");
    // Readout of one block with a stalling sink
    rdBlock = 7'h05;
    outReady = 1'b0;
    rdStart = 1'b1;
    tick(1);
    rdStart = 1'b0;
    tick(1);
    check("rd busy", rdBusy, 1); // Readout taken
    check("offset", trigOffset >= blkBits - WORD_W - 1 && trigOffset < blkBits, 1); // Last word or bit before
    tick(20);
    firstWord = outData;
    check("stall valid", outValid, 1); // Word waits for the sink
    tick(10);
    check("stall hold", outData, firstWord); // Stall loses nothing
    w = 0;
    k = 0;
    while ((rdBusy === 1'b1 || outValid === 1'b1) && k < 20000) begin
      outReady = (k % 3 != 2); // Sink drops ready every third cycle
      if (outValid === 1'b1 && outReady) w++;
      tick(1);
      k++;
    end
    outReady = 1'b1;
    check("words", w, blkBits / WORD_W); // 8 Mbit over 128 blocks
    $display("readout test done");
    // Top placement keeps storing after the trigger; reset in mid-run
    blkSel = 3'h0;
    trigSrc = TRIG_ERROR;
    place = PLACE_TOP;
    tick(2);
    start(refSeen);
    errReq = 1'b1;
    tick(1);
    errReq = 1'b0;
    tick(300);
    check("top filling", captureActive, 1); // Data after trigger still stored
    rstn = 1'b0;
    tick(4);
    check("reset active", captureActive, 0);
    check("reset blocks", blocksCaptured, 0);
    rstn = 1'b1;
    tick(4);
    $display("reset test done");
    end_sim();
  end
endmodule : test_pattern_capture_trigger_bench
